// >>> design/ssr_pkg.sv
// Purpose: Constants for the supply supervisor and reset controller.
// Assumes: Comparator and pin inputs are digital levels; one 20 MHz always-on clock.
// Notes on behaviour
// R1: Supervisor is enabled by its pin, or always when the package lacks the pin.
// R2: After power-on threshold, option bytes load, setting or disabling brownout threshold.
// R3: Brownout level picks one of three thresholds taken from option bytes.
// R4: Device held in reset while power-on/down or brownout indication is active.
// R5: Voltage detector interrupts on falling, rising, or both crossings.
// R6: Voltage detector stays inactive until software enables it.
// R7: Supervision off disables power-on reset, brownout, detector and battery domain.
// R8: External supervisor holds reset below 1.8 V, or 1.7 V at 0-70 C.
// R9: Regulator on while bypass pin low, off while high; always on without pin.
// R10: Main mode in run, low-power mode in stop, power-down only in standby.
// R11: Entering regulator power-down marks core registers and memory as lost.
// R12: Bypassed regulator makes core-domain reset pin a core power-on reset only.
// R13: Core-domain reset pin resets core logic untouched by the external reset pin.
// R14: Core-domain reset pin low refuses debug access under power-on reset.
// R15: Standby entry refused while the regulator is bypassed.
// R16: External supervisor keeps core reset low until core supply and 1.8 V main.
// R17: External supervisor asserts core reset if core supply drops with main above 1.8 V.
// R18: Detector interrupts latch pending until software clears; output gated by enable.
// R19: Comparator indications pass two flip-flops before any reset or interrupt decision.
package ssr_pkg;
    localparam int SYNC_W = 7;
    localparam int SYNC_POR = 0;
    localparam int SYNC_BRN1 = 1;
    localparam int SYNC_BRN2 = 2;
    localparam int SYNC_BRN3 = 3;
    localparam int SYNC_SVD = 4;
    localparam int SYNC_CORE_RST = 5;
    localparam int SYNC_EXT_RST = 6;
    localparam logic [1:0] BRN_LVL1 = 2'h1;
    localparam logic [1:0] BRN_LVL2 = 2'h2;
    localparam logic [1:0] BRN_LVL3 = 2'h3;
    localparam logic [1:0] BRN_OFF = 2'h0;
    localparam logic [1:0] BRN_RESET_VAL = 2'h3;
    localparam logic [1:0] EDGE_RISE_BIT = 2'h1;
    localparam logic [1:0] EDGE_FALL_BIT = 2'h2;
    localparam int OPT_LOAD_NS = 1000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int OPT_LOAD_CYC = (OPT_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0] OPT_LOAD_CYC_W = 6'(OPT_LOAD_CYC);
    typedef enum logic [3:0] {
        REG_OFF = 4'h1,
        REG_MAIN = 4'h2,
        REG_LOWPWR = 4'h4,
        REG_PWRDN = 4'h8
    } ssr_reg_mode_t;
    typedef enum logic [2:0] {
        BOOT_RESET = 3'h1,
        BOOT_LOAD = 3'h2,
        BOOT_RUN = 3'h4
    } ssr_boot_t;
endpackage : ssr_pkg

// >>> design/ssr_sync.sv
// Purpose: Two flip-flop level synchroniser, one per bit.
// Assumes: Inputs are levels; reset value is zero.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module ssr_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end
    assign q = q_reg;
endmodule : ssr_sync

// >>> design/ssr_supervisor.sv
// Purpose: Supply supervision, reset hold, voltage detector interrupt and regulator mode sequencing.
// Assumes: Analog comparisons arrive as digital levels; pins are synchronous to clk.
// Notes: Comparator, threshold and reset-pin levels pass through ssr_sync before use.
`timescale 1ns/1ps
module ssr_supervisor (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic has_sup_pin,
    input wire logic supervisor_enable_pin,
    input wire logic has_bypass_pin,
    input wire logic bypass_pin,
    input wire logic por_below,
    input wire logic [2:0] brn_below,
    input wire logic svd_below,
    input wire logic core_domain_reset_pin_b,
    input wire logic external_reset_pin_b,
    input wire logic opt_valid,
    input wire logic [1:0] opt_brn_level,
    input wire logic svd_enable,
    input wire logic [1:0] svd_edge_sel,
    input wire logic svd_irq_enable,
    input wire logic svd_clear,
    input wire logic req_stop,
    input wire logic req_standby,
    input wire logic wakeup,
    input wire logic debug_req,
    output logic sys_reset_b,
    output logic core_reset_b,
    output logic opt_loading,
    output logic [1:0] brn_level,
    output logic svd_output,
    output logic svd_pending,
    output logic svd_irq,
    output logic battery_avail,
    output logic regulator_on,
    output ssr_pkg::ssr_reg_mode_t reg_mode,
    output logic context_lost,
    output logic core_pin_gpio_ok,
    output logic debug_grant,
    output logic standby_refused
);
    import ssr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] syn;
    assign raw = {external_reset_pin_b, core_domain_reset_pin_b, svd_below, brn_below, por_below};
    ssr_sync #(.W(SYNC_W)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(raw),
        .q(syn)
    ); // see R19

    logic sup_on;
    logic reg_en;
    logic brn_hit;
    logic hold_reset;
    assign sup_on = !has_sup_pin || supervisor_enable_pin; // see R1
    assign reg_en = !has_bypass_pin || !bypass_pin; // see R9
    assign battery_avail = sup_on; // see R7

    ////////////////////////////////////////////////////////////////////////////
    // Boot sequencing and brownout level capture.
    ssr_boot_t boot_reg;
    ssr_boot_t boot_next;
    logic [1:0] brn_reg;
    logic [1:0] brn_next;
    logic [5:0] cnt_reg;
    logic [5:0] cnt_next;

    always_comb begin
        brn_hit = 1'b0;
        if (brn_reg == BRN_LVL1) begin
            brn_hit = syn[SYNC_BRN1];
        end else if (brn_reg == BRN_LVL2) begin
            brn_hit = syn[SYNC_BRN2];
        end else if (brn_reg == BRN_LVL3) begin
            brn_hit = syn[SYNC_BRN3];
        end
    end // see R3
    assign hold_reset = sup_on && (syn[SYNC_POR] || brn_hit); // see R4 R7

    always_comb begin
        boot_next = boot_reg;
        brn_next = brn_reg;
        cnt_next = cnt_reg;
        case (boot_reg)
            BOOT_RESET: begin
                cnt_next = '0;
                if (!(sup_on && syn[SYNC_POR])) begin
                    boot_next = BOOT_LOAD; // see R2
                end
            end
            BOOT_LOAD: begin
                if (sup_on && syn[SYNC_POR]) begin
                    boot_next = BOOT_RESET;
                end else if (opt_valid) begin
                    brn_next = opt_brn_level; // see R2 R3
                    boot_next = BOOT_RUN;
                end else if (cnt_reg == OPT_LOAD_CYC_W) begin
                    boot_next = BOOT_RUN;
                end else begin
                    cnt_next = cnt_reg + 6'h01;
                end
            end
            BOOT_RUN: begin
                if (hold_reset) begin
                    boot_next = BOOT_RESET; // see R4
                end
            end
            default: boot_next = BOOT_RESET;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            boot_reg <= BOOT_RESET;
            brn_reg <= BRN_RESET_VAL;
            cnt_reg <= '0;
        end else begin
            boot_reg <= boot_next;
            brn_reg <= brn_next;
            cnt_reg <= cnt_next;
        end
    end

    assign opt_loading = (boot_reg == BOOT_LOAD);
    assign brn_level = sup_on ? brn_reg : BRN_OFF;

    logic sys_rst_reg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sys_rst_reg <= 1'b0;
        end else begin
            // A brownout during option loading must still hold the reset.
            sys_rst_reg <= (boot_next == BOOT_RUN) && !hold_reset && syn[SYNC_EXT_RST]; // see R4
        end
    end
    assign sys_reset_b = sys_rst_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Voltage detector edge interrupt.
    logic svd_act;
    logic svd_prev_reg;
    logic svd_prev_next;
    logic pend_reg;
    logic pend_next;
    logic svd_event;
    assign svd_act = sup_on && svd_enable && (boot_reg == BOOT_RUN); // see R6 R7
    always_comb begin
        svd_prev_next = svd_act ? syn[SYNC_SVD] : 1'b0;
        svd_event = svd_act && svd_prev_reg != syn[SYNC_SVD]
            && ((syn[SYNC_SVD] && (svd_edge_sel & EDGE_FALL_BIT) != 2'h0)
            || (!syn[SYNC_SVD] && (svd_edge_sel & EDGE_RISE_BIT) != 2'h0)); // see R5
        pend_next = svd_event || (pend_reg && !svd_clear); // see R18
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            svd_prev_reg <= 1'b0;
            pend_reg <= 1'b0;
        end else begin
            svd_prev_reg <= svd_prev_next;
            pend_reg <= pend_next;
        end
    end
    assign svd_output = svd_prev_reg;
    assign svd_pending = pend_reg;
    assign svd_irq = pend_reg && svd_irq_enable; // see R18

    ////////////////////////////////////////////////////////////////////////////
    // Regulator mode sequencing.
    ssr_reg_mode_t mode_reg;
    ssr_reg_mode_t mode_next;
    logic lost_reg;
    logic lost_next;
    always_comb begin
        mode_next = mode_reg;
        lost_next = lost_reg && !(boot_reg == BOOT_RUN && mode_reg == REG_MAIN);
        case (mode_reg)
            REG_OFF: begin
                if (reg_en) begin
                    mode_next = REG_MAIN;
                end
            end
            REG_MAIN: begin
                if (!reg_en) begin
                    mode_next = REG_OFF;
                end else if (req_standby) begin
                    mode_next = REG_PWRDN; // see R10
                    lost_next = 1'b1; // see R11
                end else if (req_stop) begin
                    mode_next = REG_LOWPWR; // see R10
                end
            end
            REG_LOWPWR: begin
                if (wakeup || !reg_en) begin
                    mode_next = REG_MAIN;
                end
            end
            REG_PWRDN: begin
                lost_next = 1'b1;
                if (wakeup) begin
                    mode_next = REG_MAIN;
                end
            end
            default: mode_next = REG_MAIN;
        endcase
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_reg <= REG_MAIN;
            lost_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            lost_reg <= lost_next;
        end
    end
    assign reg_mode = mode_reg;
    assign regulator_on = reg_en;
    assign context_lost = lost_reg;
    assign standby_refused = !reg_en && req_standby; // see R15

    ////////////////////////////////////////////////////////////////////////////
    // Core-domain reset pin in bypass mode.
    assign core_pin_gpio_ok = reg_en; // see R12
    assign core_reset_b = reg_en ? sys_rst_reg : syn[SYNC_CORE_RST]; // see R12 R13
    assign debug_grant = debug_req && (reg_en || syn[SYNC_CORE_RST]); // see R14

    ////////////////////////////////////////////////////////////////////////////
    sequence s_det_off;
        !svd_enable ##1 !svd_enable;
    endsequence
    property p_pend_hold;
        @(posedge clk) disable iff (!rst_b) pend_reg && !svd_clear |=> pend_reg;
    endproperty
    property p_irq_gate;
        @(posedge clk) disable iff (!rst_b) svd_irq |-> svd_irq_enable && pend_reg;
    endproperty
    property p_idle_svd;
        @(posedge clk) disable iff (!rst_b) s_det_off |-> !svd_event;
    endproperty
    property p_hold;
        @(posedge clk) disable iff (!rst_b) hold_reset |=> !sys_reset_b;
    endproperty
    property p_standby;
        @(posedge clk) disable iff (!rst_b) !reg_en && mode_reg != REG_PWRDN |=> mode_reg != REG_PWRDN;
    endproperty
    property p_pwrdn_lost;
        @(posedge clk) disable iff (!rst_b) mode_reg == REG_PWRDN |-> lost_reg;
    endproperty
    property p_debug;
        @(posedge clk) disable iff (!rst_b) !reg_en && !syn[SYNC_CORE_RST] |-> !debug_grant;
    endproperty
    property p_off;
        @(posedge clk) disable iff (!rst_b) !sup_on |-> !hold_reset && !svd_act;
    endproperty
    a_pend_hold: assert property (p_pend_hold) else $error("pending flag lost"); // see R18
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enable"); // see R18
    a_idle_svd: assert property (p_idle_svd) else $error("detector active"); // see R6
    a_hold: assert property (p_hold) else $error("reset not held"); // see R4
    a_standby: assert property (p_standby) else $error("standby bypassed"); // see R15
    a_pwrdn_lost: assert property (p_pwrdn_lost) else $error("context kept"); // see R11
    a_debug: assert property (p_debug) else $error("debug granted"); // see R14
    a_off: assert property (p_off) else $error("supervision active"); // see R7
endmodule : ssr_supervisor

// >>> tb/ssr_ext_supervisor.sv
// Purpose: Model of the external supply supervisor that drives both reset pins.
// Assumes: main_ok and core_ok stand for the main and core supplies being valid.
// Notes: Pins change just after the clock edge, like every other bench stimulus.
`timescale 1ns/1ps
module ssr_ext_supervisor (
    input wire logic clk,
    input wire logic main_ok,
    input wire logic core_ok,
    output logic core_domain_reset_pin_b,
    output logic external_reset_pin_b
);
    initial begin
        core_domain_reset_pin_b = 1'b0;
        external_reset_pin_b = 1'b0;
    end
    always @(posedge clk) begin
        external_reset_pin_b <= #2 main_ok;
        core_domain_reset_pin_b <= #2 main_ok & core_ok;
    end
endmodule : ssr_ext_supervisor

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the supply supervisor and reset controller.
// Assumes: 20 MHz clock; comparator levels are driven as plain digital inputs.
// Notes: The driver queues expected values; a monitor process compares them.
`timescale 1ns/1ps
module testbench;
    import ssr_pkg::*;
    logic clk, rst_b, has_sup_pin, supervisor_enable_pin, has_bypass_pin, bypass_pin, por_below, svd_below;
    logic [2:0] brn_below;
    logic opt_valid, svd_enable, svd_irq_enable, svd_clear, req_stop, req_standby, wakeup, debug_req;
    logic [1:0] opt_brn_level, svd_edge_sel, brn_level, lvl;
    logic main_ok, core_ok, core_domain_reset_pin_b, external_reset_pin_b;
    logic sys_reset_b, core_reset_b, opt_loading, svd_output, svd_pending, svd_irq, battery_avail;
    logic regulator_on, context_lost, core_pin_gpio_ok, debug_grant, standby_refused;
    ssr_reg_mode_t reg_mode;
    logic [15:0] seed;
    string q_name[$];
    logic [3:0] q_exp[$];
    event chk;
    int err_total, tests_run;
    ssr_supervisor u_ssr_supervisor (.clk, .rst_b, .has_sup_pin, .supervisor_enable_pin, .has_bypass_pin,
        .bypass_pin, .por_below, .brn_below, .svd_below, .core_domain_reset_pin_b, .external_reset_pin_b,
        .opt_valid, .opt_brn_level, .svd_enable, .svd_edge_sel, .svd_irq_enable, .svd_clear, .req_stop,
        .req_standby, .wakeup, .debug_req, .sys_reset_b, .core_reset_b, .opt_loading, .brn_level,
        .svd_output, .svd_pending, .svd_irq, .battery_avail, .regulator_on, .reg_mode, .context_lost,
        .core_pin_gpio_ok, .debug_grant, .standby_refused);
    ssr_ext_supervisor u_ssr_ext_supervisor (.clk, .main_ok, .core_ok, .core_domain_reset_pin_b,
        .external_reset_pin_b);
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    function automatic logic [3:0] obs(input string n);
        case (n)
            "rst": return {3'h0, sys_reset_b};
            "brn": return {2'h0, brn_level};
            "pend": return {3'h0, svd_pending};
            "irq": return {3'h0, svd_irq};
            "out": return {3'h0, svd_output};
            "load": return {3'h0, opt_loading};
            "bat": return {3'h0, battery_avail};
            "mode": return reg_mode;
            "lost": return {3'h0, context_lost};
            "ron": return {3'h0, regulator_on};
            "gpio": return {3'h0, core_pin_gpio_ok};
            "dbg": return {3'h0, debug_grant};
            "sref": return {3'h0, standby_refused};
            default: return {3'h0, core_reset_b};
        endcase
    endfunction : obs
    task automatic check(input string n, input logic [3:0] seen, input logic [3:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    task automatic expect_val(input string n, input logic [3:0] v);
        q_name.push_back(n);
        q_exp.push_back(v);
        ->chk;
        #1;
    endtask : expect_val
    initial forever begin
        @(chk);
        while (q_name.size() > 0) check(q_name[0], obs(q_name.pop_front()), q_exp.pop_front());
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step
    task automatic wait_for(input string n, input logic [3:0] v);
        for (int i = 0; i < 40 && obs(n) !== v; i++) step(1);
    endtask : wait_for
    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
        step(4);
    endtask : pulse
    task automatic power_up();
        seed = lfsr_next(seed);
        lvl = 2'(seed % 3) + 2'h1;
        por_below = 1'b1;
        step(6);
        expect_val("rst", 4'h0);
        por_below = 1'b0;
        wait_for("rst", 4'h0);
        for (int i = 0; i < 40 && opt_loading !== 1'b1; i++) step(1);
        expect_val("load", 4'h1);
        opt_brn_level = lvl;
        opt_valid = 1'b1;
        step(1);
        opt_valid = 1'b0;
        wait_for("rst", 4'h1);
        expect_val("rst", 4'h1);
        expect_val("brn", {2'h0, lvl});
    endtask : power_up
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #(2000 * 50);
        err_total++;
        summarize();
    end
    initial begin
        {rst_b, has_sup_pin, has_bypass_pin, bypass_pin, svd_below, brn_below, opt_valid, svd_enable} = '0;
        {svd_irq_enable, svd_clear, req_stop, req_standby, wakeup, debug_req, opt_brn_level} = '0;
        {supervisor_enable_pin, por_below, main_ok, core_ok} = 4'hf;
        svd_edge_sel = EDGE_FALL_BIT;
        seed = 16'h7df7;
        step(12);
        expect_val("rst", 4'h0);
        expect_val("brn", {2'h0, BRN_RESET_VAL});
        expect_val("mode", REG_MAIN);
        rst_b = 1'b1;
        has_sup_pin = 1'b1;
        power_up();
        expect_val("bat", 4'h1);
        brn_below[lvl - 2'h1] = 1'b1;
        step(6);
        expect_val("rst", 4'h0);
        brn_below = 3'h0;
        power_up();
        svd_below = 1'b1;
        step(6);
        expect_val("pend", 4'h0);
        expect_val("out", 4'h0);
        svd_below = 1'b0;
        svd_enable = 1'b1;
        step(6);
        svd_below = 1'b1;
        step(6);
        expect_val("pend", 4'h1);
        expect_val("out", 4'h1);
        expect_val("irq", 4'h0);
        svd_irq_enable = 1'b1;
        step(2);
        expect_val("irq", 4'h1);
        pulse(svd_clear);
        expect_val("pend", 4'h0);
        svd_edge_sel = EDGE_RISE_BIT;
        svd_below = 1'b0;
        step(6);
        expect_val("pend", 4'h1);
        pulse(svd_clear);
        pulse(req_stop);
        expect_val("mode", REG_LOWPWR);
        pulse(wakeup);
        expect_val("mode", REG_MAIN);
        pulse(req_standby);
        expect_val("mode", REG_PWRDN);
        expect_val("lost", 4'h1);
        pulse(wakeup);
        wait_for("mode", REG_MAIN);
        has_bypass_pin = 1'b1;
        bypass_pin = 1'b1;
        step(6);
        expect_val("ron", 4'h0);
        expect_val("gpio", 4'h0);
        expect_val("mode", REG_OFF);
        req_standby = 1'b1;
        step(1);
        expect_val("sref", 4'h1);
        req_standby = 1'b0;
        debug_req = 1'b1;
        core_ok = 1'b0;
        step(6);
        expect_val("core", 4'h0);
        expect_val("rst", 4'h1);
        expect_val("dbg", 4'h0);
        core_ok = 1'b1;
        step(6);
        expect_val("dbg", 4'h1);
        bypass_pin = 1'b0;
        step(6);
        expect_val("ron", 4'h1);
        supervisor_enable_pin = 1'b0;
        por_below = 1'b1;
        step(6);
        expect_val("bat", 4'h0);
        expect_val("rst", 4'h1);
        main_ok = 1'b0;
        step(6);
        expect_val("rst", 4'h0);
        step(2);
        summarize();
    end
endmodule : testbench
